// ==== common/addr20_params.svh ====
// constants for the address-bit-20 mask and test strap block
// assumes inclusion by bare name from the design files
`ifndef ADDR20_PARAMS_SVH
`define ADDR20_PARAMS_SVH

// configuration bytes: word address on host lines 31:2 and byte lanes
`define CFG_WORD_ADDR 30'h0000030c
`define CFG_C30_LANE 0
`define CFG_C31_LANE 1
`define CFG_C30_OFFSET 12'hc30
`define CFG_C31_OFFSET 12'hc31

// field positions inside the configuration bytes
`define C30_FAST_MASK_BIT 0
`define C30_REV_LSB 2
`define C30_REV_MSB 3
`define C31_EARLY_WE_BIT 0

// reset values
`define C30_FAST_MASK_RESET 1'b0
`define C31_RESET 8'h00

// timing counts in sys_clk cycles
`define STRAP_SETTLE_CYCLES 2'd2
`define STROBE_NORMAL_DELAY 2'd2

// bit positions inside the pin synchroniser vector
`define PIN_DR_CLK 0
`define PIN_MODE_N 1
`define PIN_GATE 2
`define PIN_ISA_N 3
`define PIN_WR 4
`define PIN_DC 5
`define PIN_MIO 6
`define PIN_ADS_N 7
`define PIN_BE_LSB 8
`define PIN_BE_MSB 11
`define PIN_ADDR_LSB 12
`define PIN_ADDR_MSB 41
`define PIN_DATA_LSB 42
`define PIN_DATA_MSB 73
`define PIN_SYNC_W 74

`endif

// ==== common/addr20_pkg.sv ====
// types shared by the mask/strap block and its cache strobe generator
// assumes nothing of its surroundings
package addr20_pkg;

  typedef logic [3:0] lanes_t;
  typedef logic [29:0] host_addr_t;
  typedef logic [31:0] host_data_t;

  typedef enum logic [1:0] {
    MODE_STRAP_WAIT,
    MODE_NORMAL,
    MODE_TRISTATE
  } mode_e;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK,
    BUS_RECOVER
  } bus_e;

endpackage : addr20_pkg

// ==== rtl/cache_strobe_gen.sv ====
// cache byte write strobe generator, early or normal timing
// assumes write_req and lanes come from logic on sys_clk
`timescale 1ns/10ps
`include "addr20_params.svh"

module cache_strobe_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request side
  input wire logic write_req,
  input wire addr20_pkg::lanes_t lanes,
  input wire logic early_en,
  input wire logic dr_edge,
  // strobes, active low
  output addr20_pkg::lanes_t strobes_n
);
  import addr20_pkg::*;

  typedef struct packed {
    logic pend;
    logic [1:0] cnt;
    lanes_t lanes;
    lanes_t strobes_n;
  } strobe_s;

  strobe_s st_r;
  strobe_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.strobes_n = 4'hf;
    if (st_r.pend)
    begin
      // early timing follows the double-rate edge, but never later than normal timing
      if ((early_en && dr_edge) || (st_r.cnt == (`STROBE_NORMAL_DELAY - 2'd1)))
      begin
        st_nxt.strobes_n = ~st_r.lanes;
        st_nxt.pend = 1'b0;
      end
      st_nxt.cnt = st_r.cnt + 2'd1;
    end
    else if (write_req)
    begin
      st_nxt.pend = 1'b1;
      st_nxt.cnt = 2'd0;
      st_nxt.lanes = lanes;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{pend: 1'b0, cnt: 2'd0, lanes: 4'h0, strobes_n: 4'hf};
    else
      st_r <= st_nxt;
  end

  assign strobes_n = st_r.strobes_n;

  property p_early_strobe;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r.pend && early_en && dr_edge && (st_r.lanes != 4'h0)) |=> (strobes_n == ~$past(st_r.lanes));
  endproperty
  a_early_strobe: assert property (p_early_strobe) else $error("early strobe missed the double-rate edge");

  property p_strobe_bounded;
    @(posedge sys_clk) disable iff (!rst_n)
      (write_req && !st_r.pend && (lanes != 4'h0)) |-> ##[2:3] (strobes_n == ~$past(lanes, 2) || strobes_n == ~$past(lanes, 3));
  endproperty
  a_strobe_bounded: assert property (p_strobe_bounded) else $error("cache strobe not issued in time");

  property p_strobe_one_cycle;
    @(posedge sys_clk) disable iff (!rst_n)
      (strobes_n != 4'hf) |=> (strobes_n == 4'hf);
  endproperty
  a_strobe_one_cycle: assert property (p_strobe_one_cycle) else $error("cache strobe wider than one cycle");

endmodule : cache_strobe_gen

// ==== rtl/addr20_mask_and_test_strap.sv ====
// address-bit-20 mask, configuration bytes and tristate board-test strap
// assumes all host pins are asynchronous to sys_clk; cache_write_req is on sys_clk
//
// Operation
// - mask active when fast bit or gate set
// - revision bits read fixed, writes ignored
// - test mode floats every output pin
// - straps sampled at reset release pick mode
// - mask output forces host A20 low
// - early write bit times strobes from double clock
// - status inputs sampled with address lines
// - write/read sampled with lanes, ignored for ISA
// - byte lanes select valid register and cache bytes
// - registers decoded from address lines 31:2
`timescale 1ns/10ps
`include "addr20_params.svh"

module addr20_mask_and_test_strap #(
  parameter logic [1:0] REVISION = 2'h1, // arbitrary value
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host address and status
  input wire addr20_pkg::host_addr_t host_address_lines,
  input wire addr20_pkg::lanes_t host_byte_lane_enables_n,
  input wire logic host_addr_strobe_n,
  input wire logic host_mem_or_io,
  input wire logic host_data_or_control,
  input wire logic host_write_or_read,
  input wire logic isa_master16_n,
  // host data bus and ready
  input wire addr20_pkg::host_data_t host_data_in,
  output addr20_pkg::host_data_t host_data_out,
  output logic host_data_oe,
  output logic host_ready_n,
  output logic host_ready_oe,
  // gate line, doubles as the test select strap
  input wire logic keyboard_gate_in,
  input wire logic test_mode_strap_n,
  // mask output
  output logic addr_bit20_mask_out_n,
  output logic addr_bit20_mask_oe,
  // cache strobes
  input wire logic double_rate_clock,
  input wire logic cache_write_req,
  output addr20_pkg::lanes_t cache_byte_write_strobes_n,
  output logic cache_byte_write_strobes_oe
);
  import addr20_pkg::*;

  if (LANES != 4)
  begin : g_bad_lanes
    $error("only four byte lanes are supported");
  end

  typedef struct packed {
    logic [`PIN_SYNC_W-1:0] sync1;
    logic [`PIN_SYNC_W-1:0] sync2;
    logic dr_prev;
    mode_e mode;
    logic [1:0] strap_cnt;
    bus_e bus;
    logic fast_mask;
    logic [7:0] cfg31;
    logic cyc_mio;
    logic cyc_dc;
    logic cyc_wr;
    lanes_t cyc_be_n;
    logic mask_n;
    logic mask_oe;
    logic strobes_oe;
    logic ready_n;
    logic ready_oe;
    host_data_t data_out;
    logic data_oe;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [`PIN_SYNC_W-1:0] pins;
  logic [`PIN_SYNC_W-1:0] s;
  logic gate_s;
  logic hit;
  logic wr_eff;
  logic dr_edge;
  lanes_t strobes_n;

  assign pins = {host_data_in, host_address_lines, host_byte_lane_enables_n, host_addr_strobe_n,
                 host_mem_or_io, host_data_or_control, host_write_or_read, isa_master16_n,
                 keyboard_gate_in, test_mode_strap_n, double_rate_clock};
  assign s = st_r.sync2;
  assign gate_s = s[`PIN_GATE];
  assign dr_edge = s[`PIN_DR_CLK] && !st_r.dr_prev;
  // I/O data cycle at the configuration word, with one of its lanes enabled
  assign hit = (s[`PIN_ADDR_MSB:`PIN_ADDR_LSB] == `CFG_WORD_ADDR) && !s[`PIN_MIO] && s[`PIN_DC]
               && (!s[`PIN_BE_LSB + `CFG_C30_LANE] || !s[`PIN_BE_LSB + `CFG_C31_LANE]);
  // an ISA master drives no valid write/read line, so its cycles never write
  assign wr_eff = s[`PIN_WR] && s[`PIN_ISA_N];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.dr_prev = s[`PIN_DR_CLK];
    st_nxt.mask_n = !(st_r.fast_mask || gate_s);
    case (st_r.mode)
      MODE_STRAP_WAIT:
      begin
        // synchronised straps need two cycles after release before they are valid
        st_nxt.strap_cnt = st_r.strap_cnt + 2'd1;
        if (st_r.strap_cnt == `STRAP_SETTLE_CYCLES)
        begin
          if (!s[`PIN_MODE_N] && gate_s)
            st_nxt.mode = MODE_TRISTATE;
          else
            st_nxt.mode = MODE_NORMAL;
        end
      end
      MODE_NORMAL:
      begin
        st_nxt.mask_oe = 1'b1;
        st_nxt.strobes_oe = 1'b1;
        case (st_r.bus)
          BUS_IDLE:
          begin
            if (!s[`PIN_ADS_N])
            begin
              st_nxt.cyc_mio = s[`PIN_MIO];
              st_nxt.cyc_dc = s[`PIN_DC];
              st_nxt.cyc_wr = wr_eff;
              st_nxt.cyc_be_n = s[`PIN_BE_MSB:`PIN_BE_LSB];
              if (hit)
              begin
                if (wr_eff && !s[`PIN_BE_LSB + `CFG_C30_LANE])
                  st_nxt.fast_mask = s[`PIN_DATA_LSB + `C30_FAST_MASK_BIT];
                if (wr_eff && !s[`PIN_BE_LSB + `CFG_C31_LANE])
                  st_nxt.cfg31 = s[`PIN_DATA_LSB + 15:`PIN_DATA_LSB + 8];
                st_nxt.data_out = 32'h0;
                if (!s[`PIN_BE_LSB + `CFG_C30_LANE])
                  st_nxt.data_out[7:0] = {4'h0, REVISION, 1'b0, st_r.fast_mask};
                if (!s[`PIN_BE_LSB + `CFG_C31_LANE])
                  st_nxt.data_out[15:8] = st_r.cfg31;
                st_nxt.data_oe = !wr_eff;
                st_nxt.ready_n = 1'b0;
                st_nxt.ready_oe = 1'b1;
                st_nxt.bus = BUS_ACK;
              end
            end
          end
          BUS_ACK:
          begin
            // ready is driven high for a cycle before it floats
            st_nxt.ready_n = 1'b1;
            st_nxt.data_oe = 1'b0;
            st_nxt.bus = BUS_RECOVER;
          end
          BUS_RECOVER:
          begin
            st_nxt.ready_oe = 1'b0;
            st_nxt.bus = BUS_IDLE;
          end
          default:
          begin
            st_nxt.bus = BUS_IDLE;
          end
        endcase
      end
      MODE_TRISTATE:
      begin
        // only a reset leaves this mode
        st_nxt.mode = MODE_TRISTATE;
        st_nxt.mask_oe = 1'b0;
        st_nxt.strobes_oe = 1'b0;
        st_nxt.ready_oe = 1'b0;
        st_nxt.data_oe = 1'b0;
      end
      default:
      begin
        st_nxt.mode = MODE_STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{sync1: '0, sync2: '0, dr_prev: 1'b0, mode: MODE_STRAP_WAIT, strap_cnt: 2'd0,
                bus: BUS_IDLE, fast_mask: `C30_FAST_MASK_RESET, cfg31: `C31_RESET, cyc_mio: 1'b0,
                cyc_dc: 1'b0, cyc_wr: 1'b0, cyc_be_n: 4'hf, mask_n: 1'b1, mask_oe: 1'b0,
                strobes_oe: 1'b0, ready_n: 1'b1, ready_oe: 1'b0, data_out: 32'h0, data_oe: 1'b0};
    else
      st_r <= st_nxt;
  end

  cache_strobe_gen u_strobes (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .write_req(cache_write_req),
    .lanes(~st_r.cyc_be_n),
    .early_en(st_r.cfg31[`C31_EARLY_WE_BIT]),
    .dr_edge(dr_edge),
    .strobes_n(strobes_n)
  );

  assign host_data_out = st_r.data_out;
  assign host_data_oe = st_r.data_oe;
  assign host_ready_n = st_r.ready_n;
  assign host_ready_oe = st_r.ready_oe;
  assign addr_bit20_mask_out_n = st_r.mask_n;
  assign addr_bit20_mask_oe = st_r.mask_oe;
  assign cache_byte_write_strobes_n = strobes_n;
  assign cache_byte_write_strobes_oe = st_r.strobes_oe;

  property p_mask_or;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 (addr_bit20_mask_out_n == !($past(st_r.fast_mask) || $past(gate_s)));
  endproperty
  a_mask_or: assert property (p_mask_or) else $error("mask output is not the or of its sources");

  property p_rev_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (host_data_oe && !st_r.cyc_be_n[`CFG_C30_LANE]) |-> (host_data_out[`C30_REV_MSB:`C30_REV_LSB] == REVISION);
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision field read wrong");

  property p_tristate_all;
    @(posedge sys_clk) disable iff (!rst_n)
      ($past(st_r.mode) == MODE_TRISTATE) |-> !(host_data_oe || host_ready_oe || addr_bit20_mask_oe
                                                || cache_byte_write_strobes_oe);
  endproperty
  a_tristate_all: assert property (p_tristate_all) else $error("a pin is driven in test mode");

  property p_strap_decode;
    @(posedge sys_clk) disable iff (!rst_n)
      ($past(st_r.mode) == MODE_STRAP_WAIT && st_r.mode != MODE_STRAP_WAIT)
        |-> ((st_r.mode == MODE_TRISTATE) == (!$past(s[`PIN_MODE_N]) && $past(gate_s)));
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("strap decode chose the wrong mode");

  property p_tristate_held;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r.mode == MODE_TRISTATE) |=> (st_r.mode == MODE_TRISTATE);
  endproperty
  a_tristate_held: assert property (p_tristate_held) else $error("test mode left without reset");

  property p_status_capture;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r.mode == MODE_NORMAL && st_r.bus == BUS_IDLE && !s[`PIN_ADS_N])
        |=> (st_r.cyc_mio == $past(s[`PIN_MIO]) && st_r.cyc_dc == $past(s[`PIN_DC])
             && st_r.cyc_wr == $past(wr_eff) && st_r.cyc_be_n == $past(s[`PIN_BE_MSB:`PIN_BE_LSB]));
  endproperty
  a_status_capture: assert property (p_status_capture) else $error("status not captured with address");

  property p_isa_no_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r.bus == BUS_IDLE && !s[`PIN_ADS_N] && !s[`PIN_ISA_N]) |=> ($stable(st_r.fast_mask) && $stable(st_r.cfg31));
  endproperty
  a_isa_no_write: assert property (p_isa_no_write) else $error("isa master cycle changed a register");

  property p_lane_gate;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r.bus == BUS_IDLE && s[`PIN_BE_LSB + `CFG_C30_LANE]) |=> $stable(st_r.fast_mask);
  endproperty
  a_lane_gate: assert property (p_lane_gate) else $error("disabled lane wrote the fast mask bit");

  property p_decode_ready;
    @(posedge sys_clk) disable iff (!rst_n)
      (st_r.mode == MODE_NORMAL && st_r.bus == BUS_IDLE && !s[`PIN_ADS_N] && hit)
        |=> (!host_ready_n && host_ready_oe) ##1 (host_ready_n && host_ready_oe) ##1 !host_ready_oe;
  endproperty
  a_decode_ready: assert property (p_decode_ready) else $error("register access not answered");

endmodule : addr20_mask_and_test_strap

// ==== dv/host_bus_model.sv ====
// host processor bus model that runs register cycles on the block's pins
// assumes pins change on sys_clk falling edges and answers arrive on ready
`timescale 1ns/10ps

module host_bus_model (
  // clock
  input wire logic sys_clk,
  // request pins
  output addr20_pkg::host_addr_t addr,
  output addr20_pkg::lanes_t be_n,
  output logic ads_n,
  output logic mio,
  output logic dc,
  output logic wr,
  output addr20_pkg::host_data_t wdata,
  // answer pins
  input wire addr20_pkg::host_data_t rdata,
  input wire logic rdata_oe,
  input wire logic rdy_n,
  input wire logic rdy_oe,
  input wire logic mask_n,
  output logic a20_forced
);
  import addr20_pkg::*;

  // external masking path of a processor without its own cache
  assign a20_forced = !mask_n;

  initial
  begin
    ads_n = 1'b1;
    addr = '0;
    be_n = 4'hf;
    mio = 1'b1;
    dc = 1'b0;
    wr = 1'b0;
    wdata = '0;
  end

  task bus_cycle(input host_addr_t a, input logic m, input logic w, input lanes_t b, input host_data_t wd,
                 output logic ack, output host_data_t rd);
    int i;
    @(negedge sys_clk);
    ads_n = 1'b0;
    addr = a;
    mio = m;
    dc = 1'b1;
    wr = w;
    be_n = b;
    wdata = wd;
    ack = 1'b0;
    rd = '0;
    for (i = 0; i < 8 && !ack; i++)
    begin
      @(negedge sys_clk);
      ads_n = 1'b1;
      if (rdy_oe === 1'b1 && rdy_n === 1'b0)
      begin
        ack = 1'b1;
        rd = (rdata_oe === 1'b1) ? rdata : ~rdata;
      end
    end
    // released lines show the inverse and the lanes go inactive, so a stale value cannot pass
    addr = ~a;
    mio = ~m;
    dc = 1'b0;
    wr = ~w;
    be_n = 4'hf;
    wdata = ~wd;
    repeat (3) @(negedge sys_clk);
  endtask : bus_cycle
endmodule : host_bus_model

// ==== dv/tb_addr20_mask_and_test_strap.sv ====
// self-checking bench for the mask, configuration bytes and test strap
// assumes the host bus model file and the design package are compiled first
`timescale 1ns/10ps
`include "addr20_params.svh"

module tb_addr20_mask_and_test_strap;
  import addr20_pkg::*;

  localparam logic [1:0] REV = 2'h2; // arbitrary value
  localparam host_addr_t CA = `CFG_WORD_ADDR;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  host_addr_t addr;
  lanes_t be_n;
  lanes_t strobes_n;
  host_data_t wdata;
  host_data_t rdata;
  host_data_t rd;
  logic ads_n, mio, dc, wr, isa_n, gate, mode_n, drclk, creq, ack, a20_forced;
  logic data_oe, rdy_n, rdy_oe, mask_n, mask_oe, cs_oe;
  int err_count = 0;
  int num_checks = 0;

  always #50 sys_clk = ~sys_clk;

  addr20_mask_and_test_strap #(.REVISION(REV), .LANES(4)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .host_address_lines(addr), .host_byte_lane_enables_n(be_n),
    .host_addr_strobe_n(ads_n), .host_mem_or_io(mio), .host_data_or_control(dc), .host_write_or_read(wr),
    .isa_master16_n(isa_n), .host_data_in(wdata), .host_data_out(rdata), .host_data_oe(data_oe),
    .host_ready_n(rdy_n), .host_ready_oe(rdy_oe), .keyboard_gate_in(gate), .test_mode_strap_n(mode_n),
    .addr_bit20_mask_out_n(mask_n), .addr_bit20_mask_oe(mask_oe), .double_rate_clock(drclk),
    .cache_write_req(creq), .cache_byte_write_strobes_n(strobes_n), .cache_byte_write_strobes_oe(cs_oe));

  host_bus_model hb (
    .sys_clk(sys_clk), .addr(addr), .be_n(be_n), .ads_n(ads_n), .mio(mio), .dc(dc), .wr(wr), .wdata(wdata),
    .rdata(rdata), .rdata_oe(data_oe), .rdy_n(rdy_n), .rdy_oe(rdy_oe), .mask_n(mask_n), .a20_forced(a20_forced));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task cyc(input host_addr_t a, input logic m, input logic w, input lanes_t b, input host_data_t wd, input logic ea);
    hb.bus_cycle(a, m, w, b, wd, ack, rd);
    chk({31'h0, ack}, {31'h0, ea});
  endtask : cyc

  // straps are held well past the settle window before anything else moves
  task do_reset(input logic mn, input logic g);
    @(negedge sys_clk);
    rst_n = 1'b0;
    mode_n = mn;
    gate = g;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask : do_reset

  task strobe(input lanes_t exp, input int lo, input int hi, input logic dr);
    int k;
    int at;
    int n;
    lanes_t seen;
    at = -1;
    n = 0;
    seen = 4'hf;
    // the double-rate edge is launched a cycle ahead so it is synchronised while the request pends
    drclk = dr;
    @(negedge sys_clk);
    creq = 1'b1;
    @(negedge sys_clk);
    creq = 1'b0;
    for (k = 1; k <= 4; k++)
    begin
      @(negedge sys_clk);
      if (strobes_n !== 4'hf)
      begin
        n++;
        if (at < 0)
        begin
          at = k;
          seen = strobes_n;
        end
      end
    end
    drclk = 1'b0;
    chk({28'h0, seen}, {28'h0, exp});
    chk({31'h0, at >= lo && at <= hi}, 32'h1);
    chk(n, 1);
  endtask : strobe

  initial
  begin
    repeat (6000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end

  initial
  begin
    isa_n = 1'b1;
    gate = 1'b0;
    mode_n = 1'b1;
    drclk = 1'b0;
    creq = 1'b0;
    do_reset(1'b1, 1'b0);
    chk({27'h0, mask_oe, mask_n, cs_oe, rdy_oe, data_oe}, 32'h1c);
    cyc(CA, 1'b0, 1'b0, 4'h0, '0, 1'b1);
    chk(rd, {28'h0, REV, 2'b00});
    cyc(CA, 1'b0, 1'b1, 4'he, 32'h0000_00ff, 1'b1);
    chk({31'h0, mask_n}, 32'h0);
    cyc(CA, 1'b0, 1'b0, 4'hc, '0, 1'b1);
    chk(rd, {28'h0, REV, 2'b01});
    cyc(CA, 1'b0, 1'b1, 4'he, 32'h0, 1'b1);
    chk({31'h0, mask_n}, 32'h1);
    gate = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({31'h0, mask_n}, 32'h0);
    chk({31'h0, a20_forced}, 32'h1);
    gate = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({31'h0, mask_n}, 32'h1);
    // lane 0 data must not land while only lane 1 is enabled
    cyc(CA, 1'b0, 1'b1, 4'hd, 32'h0000_a4ff, 1'b1);
    cyc(CA, 1'b0, 1'b0, 4'hc, '0, 1'b1);
    chk(rd, {16'h0, 8'ha4, 4'h0, REV, 2'b00});
    strobe(4'hc, 2, 2, 1'b1);
    isa_n = 1'b0;
    cyc(CA, 1'b0, 1'b1, 4'hd, 32'h0000_ff00, 1'b1);
    isa_n = 1'b1;
    cyc(CA, 1'b0, 1'b0, 4'hc, '0, 1'b1);
    chk(rd[15:8], 32'ha4);
    cyc(CA + 30'h1, 1'b0, 1'b0, 4'h0, '0, 1'b0);
    cyc(CA, 1'b1, 1'b0, 4'h0, '0, 1'b0);
    cyc(CA, 1'b0, 1'b1, 4'hd, 32'h0000_0100, 1'b1);
    strobe(4'hd, 1, 1, 1'b1);
    do_reset(1'b0, 1'b1);
    chk({28'h0, mask_oe, cs_oe, rdy_oe, data_oe}, 32'h0);
    mode_n = 1'b1;
    cyc(CA, 1'b0, 1'b0, 4'h0, '0, 1'b0);
    chk({28'h0, mask_oe, cs_oe, rdy_oe, data_oe}, 32'h0);
    // both straps low is reserved, so the select strap is checked high against a high mode strap
    do_reset(1'b1, 1'b1);
    chk({30'h0, mask_oe, a20_forced}, 32'h3);
    cyc(CA, 1'b0, 1'b0, 4'h0, '0, 1'b1);
    stop_test();
  end
endmodule : tb_addr20_mask_and_test_strap
